// File: src/wocfg_top.sv
`timescale 1ns/1ps
// Operation
// - one write per register after each reset
// - reset clears all; trip bit only on power-up
// - registers at two consecutive byte addresses
// - reads return contents at any time
// - serial clock from bus or oscillator
// - oscillator pins follow clock and crystal enables
// - crystal bit picks clock monitor range
// - stabilization 4096 ticks crystal, 16 external
// - slow bit picks slow crystal, low range
// - timebase select adds divide by 128
// - oscillator in stop keeps clocks running
// - pullup on while disable bit clear
// - watchdog 8176 or 262128 oscillator ticks
// - monitor kept in stop when bit set
// - stop recovery choice of 32 or 4096
// - short bit 32 ticks; voltage wake long
// - stop disabled makes stop illegal opcode
// - power disable bit switches monitor off
module wocfg_top (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  // processor bus
  input wire wocfg_pkg::wocfg_bus_t bus,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  // rate enables from the clock tree
  input wire logic bus_tick,
  input wire logic osc_tick,
  // events from the processor and system
  input wire logic stop_exec,
  input wire logic wake_event,
  input wire logic low_voltage_wake,
  input wire logic watchdog_service,
  input wire logic stab_start,
  // option contents
  output wocfg_pkg::wocfg_opt_two_t opt_two,
  output wocfg_pkg::wocfg_opt_one_t opt_one,
  // clock and pin control
  output logic serial_clk_tick,
  output logic osc_pin_in_is_clock,
  output logic osc_pin_out_is_crystal,
  output logic port_c_bit_four_gpio,
  output logic port_c_bit_three_gpio,
  output logic monitor_expect_crystal,
  output logic monitor_expect_slow,
  output logic stab_done,
  output logic stab_busy_q,
  output logic timebase_tick,
  output logic clocks_running,
  output logic slave_select_pullup_en,
  // watchdog, voltage monitor, stop
  output logic watchdog_enabled,
  output logic watchdog_timeout,
  output logic low_voltage_monitor_on,
  output logic low_voltage_reset_en,
  output logic voltage_trip_mode,
  output logic stop_mode,
  output logic illegal_opcode,
  output logic cpu_resume
);

  // ==================================================================
  // address decode
  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [15:0] t);
    addr_hit = (a == t);
  endfunction : addr_hit

  logic wr_two; // write to register two
  logic wr_one; // write to register one
  logic [7:0] two_q; // raw register two
  logic [7:0] one_q; // raw register one
  logic two_locked; // register two used
  logic one_locked; // register one used
  logic [7:0] rdata_d; // next read data
  logic rvalid_d; // next read valid

  assign wr_two = bus.wr && addr_hit(bus.addr, wocfg_pkg::OPT_TWO_ADDR);
  assign wr_one = bus.wr && addr_hit(bus.addr, wocfg_pkg::OPT_ONE_ADDR);

  // ==================================================================
  // the two write-once registers
  wocfg_once_reg #(
    .USED_MASK(wocfg_pkg::OPT_TWO_USED),
    .KEEP_MASK(wocfg_pkg::OPT_NONE_KEEP)
  ) u_two (
    .core_clk(core_clk),
    .rst(rst),
    .por(por),
    .wr_en(wr_two),
    .wdata(bus.wdata),
    .value_q(two_q),
    .locked_q(two_locked)
  );

  wocfg_once_reg #(
    .USED_MASK(wocfg_pkg::OPT_ONE_USED),
    .KEEP_MASK(wocfg_pkg::OPT_ONE_KEEP)
  ) u_one (
    .core_clk(core_clk),
    .rst(rst),
    .por(por),
    .wr_en(wr_one),
    .wdata(bus.wdata),
    .value_q(one_q),
    .locked_q(one_locked)
  );

  assign opt_two = wocfg_pkg::wocfg_opt_two_t'(two_q);
  assign opt_one = wocfg_pkg::wocfg_opt_one_t'(one_q);

  // ==================================================================
  // read path: contents whether locked or not, unmapped reads zero
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = bus.rd;
    if (bus.rd)
    begin
      if (addr_hit(bus.addr, wocfg_pkg::OPT_TWO_ADDR))
        rdata_d = two_q;
      else if (addr_hit(bus.addr, wocfg_pkg::OPT_ONE_ADDR))
        rdata_d = one_q;
      else
        rdata_d = 8'h00;
    end
  end

  // read data register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==================================================================
  // clock source and pin function decode
  assign serial_clk_tick = opt_two.serial_baud_clock_source ?
                           bus_tick : osc_tick;
  assign osc_pin_in_is_clock = opt_two.external_clock_enable;
  assign osc_pin_out_is_crystal = opt_two.external_clock_enable &&
                                  opt_two.crystal_enable;
  assign port_c_bit_four_gpio = !osc_pin_in_is_clock;
  assign port_c_bit_three_gpio = !osc_pin_out_is_crystal;
  assign monitor_expect_crystal = opt_two.crystal_enable;
  assign monitor_expect_slow = opt_two.slow_crystal_select;
  assign slave_select_pullup_en = !opt_two.slave_select_pullup_disable;

  // ==================================================================
  // stop mode sequencer
  wocfg_pkg::wocfg_stop_t state_q; // sequencer state
  wocfg_pkg::wocfg_stop_t state_d; // next state
  logic long_q; // long recovery forced
  logic long_d; // next long flag
  logic rec_clear; // restart recovery count
  logic rec_done; // recovery count ended
  logic [17:0] rec_limit; // recovery length
  logic osc_run; // oscillator ticks that reach logic

  // clocks stop in stop mode unless kept running
  assign clocks_running = (state_q != wocfg_pkg::ST_STOP) ||
                          opt_two.oscillator_in_stop_enable;
  assign osc_run = osc_tick && clocks_running;
  assign stop_mode = (state_q == wocfg_pkg::ST_STOP);

  // recovery length from the short bit, long after a voltage wake
  assign rec_limit = (opt_one.short_stop_recovery && !long_q) ?
                     wocfg_pkg::REC_SHORT : wocfg_pkg::REC_LONG;
  assign rec_clear = (state_q != wocfg_pkg::ST_RECOVER);

  wocfg_tick_counter #(
    .W(wocfg_pkg::CNT_W)
  ) u_rec (
    .core_clk(core_clk),
    .rst(rst),
    .clear(rec_clear),
    .tick(osc_tick),
    .limit(rec_limit),
    .done(rec_done)
  );

  // next state of the stop sequencer
  always_comb
  begin
    state_d = state_q;
    long_d = long_q;
    illegal_opcode = 1'b0;
    cpu_resume = 1'b0;
    case (state_q)
      wocfg_pkg::ST_RUN:
      begin
        if (stop_exec && !opt_one.stop_instruction_enable)
          illegal_opcode = 1'b1;
        else if (stop_exec)
          state_d = wocfg_pkg::ST_STOP;
      end
      wocfg_pkg::ST_STOP:
      begin
        if (wake_event || low_voltage_wake)
        begin
          state_d = wocfg_pkg::ST_RECOVER;
          long_d = low_voltage_wake;
        end
      end
      wocfg_pkg::ST_RECOVER:
      begin
        if (rec_done)
        begin
          state_d = wocfg_pkg::ST_RUN;
          cpu_resume = 1'b1;
          long_d = 1'b0;
        end
      end
      default:
        state_d = wocfg_pkg::ST_RUN;
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= wocfg_pkg::ST_RUN;
      long_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      long_q <= long_d;
    end
  end

  // ==================================================================
  // clock monitor stabilization divider
  logic stab_busy_d; // next busy flag
  logic stab_hit; // divider reached its limit
  logic [17:0] stab_limit; // divider length

  assign stab_limit = opt_two.crystal_enable ? wocfg_pkg::STAB_CRYSTAL :
                      wocfg_pkg::STAB_EXTERNAL;
  assign stab_done = stab_hit && stab_busy_q;

  wocfg_tick_counter #(
    .W(wocfg_pkg::CNT_W)
  ) u_stab (
    .core_clk(core_clk),
    .rst(rst),
    .clear(stab_start || !stab_busy_q),
    .tick(osc_run),
    .limit(stab_limit),
    .done(stab_hit)
  );

  // busy from start until the divider times out
  always_comb
  begin
    stab_busy_d = stab_busy_q;
    if (stab_start)
      stab_busy_d = 1'b1;
    else if (stab_done)
      stab_busy_d = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      stab_busy_q <= 1'b0;
    else
      stab_busy_q <= stab_busy_d;
  end

  // ==================================================================
  // timebase prescaler and watchdog
  logic tb_div_tick; // divide-by-128 output
  logic [17:0] wd_limit; // watchdog period

  wocfg_tick_counter #(
    .W(wocfg_pkg::CNT_W)
  ) u_tb (
    .core_clk(core_clk),
    .rst(rst),
    .clear(!opt_two.timebase_clock_select),
    .tick(osc_run),
    .limit(wocfg_pkg::TB_DIVIDE),
    .done(tb_div_tick)
  );

  assign timebase_tick = opt_two.timebase_clock_select ?
                         tb_div_tick : osc_run;

  assign watchdog_enabled = !opt_one.watchdog_disable;
  assign wd_limit = opt_one.watchdog_rate_select ? wocfg_pkg::WDOG_FAST :
                    wocfg_pkg::WDOG_SLOW;

  wocfg_tick_counter #(
    .W(wocfg_pkg::CNT_W)
  ) u_wd (
    .core_clk(core_clk),
    .rst(rst),
    .clear(watchdog_service || !watchdog_enabled || stop_mode),
    .tick(osc_run),
    .limit(wd_limit),
    .done(watchdog_timeout)
  );

  // ==================================================================
  // low-voltage monitor control
  assign low_voltage_monitor_on = !opt_one.voltage_monitor_power_disable &&
    (!stop_mode || opt_one.voltage_monitor_in_stop);
  assign low_voltage_reset_en = !opt_one.voltage_monitor_reset_disable;
  assign voltage_trip_mode = opt_one.voltage_trip_mode;

  // ==================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  lock_holds_a: assert property (wr_one && one_locked |=> $stable(one_q))
    else $error("locked register one changed");
  first_write_a: assert property (wr_two && !two_locked |=> two_locked &&
    two_q == ($past(bus.wdata) & wocfg_pkg::OPT_TWO_USED))
    else $error("first write not stored");
  read_back_a: assert property (bus.rd &&
    addr_hit(bus.addr, wocfg_pkg::OPT_ONE_ADDR) |=> rvalid_q &&
    rdata_q == $past(one_q))
    else $error("read data wrong");
  serial_src_a: assert property (serial_clk_tick ==
    (opt_two.serial_baud_clock_source ? bus_tick : osc_tick))
    else $error("serial clock source wrong");
  pin_map_a: assert property (osc_pin_out_is_crystal |->
    osc_pin_in_is_clock && opt_two.crystal_enable)
    else $error("crystal pin without clock enable");
  illegal_stop_a: assert property (state_q == wocfg_pkg::ST_RUN &&
    stop_exec && !opt_one.stop_instruction_enable |-> illegal_opcode
    ##1 state_q == wocfg_pkg::ST_RUN)
    else $error("disabled stop not refused");
  short_rec_a: assert property ($rose(state_q == wocfg_pkg::ST_RECOVER)
    && !long_q && opt_one.short_stop_recovery ##0 osc_tick [*8]
    |-> ##[0:32] cpu_resume)
    else $error("short recovery too long");
  lvm_stop_a: assert property (stop_mode &&
    !opt_one.voltage_monitor_in_stop |-> !low_voltage_monitor_on)
    else $error("monitor on in stop");
  wd_off_a: assert property (opt_one.watchdog_disable |->
    !watchdog_timeout)
    else $error("disabled watchdog timed out");
  stab_ext_a: assert property (stab_start && !opt_two.crystal_enable
    ##1 (osc_run && !stab_start) [*8] |-> stab_busy_q)
    else $error("stabilization ended early");

endmodule : wocfg_top

// File: src/wocfg_pkg.sv
// ====================================================================
// shared constants and types for the write-once option registers
package wocfg_pkg;

  // ==================================================================
  // byte addresses on the processor bus
  localparam logic [15:0] OPT_TWO_ADDR = 16'h001E; // option register two
  localparam logic [15:0] OPT_ONE_ADDR = 16'h001F; // option register one

  // ==================================================================
  // reset values and field positions
  localparam logic [7:0] OPT_RESET = 8'h00; // every bit clear
  localparam logic [7:0] OPT_TWO_USED = 8'h7F; // bit 7 reads zero
  localparam logic [7:0] OPT_ONE_USED = 8'hFF; // all bits stored
  localparam logic [7:0] OPT_ONE_KEEP = 8'h08; // trip mode survives rst
  localparam logic [7:0] OPT_NONE_KEEP = 8'h00; // nothing survives rst

  // ==================================================================
  // counts of oscillator clock ticks
  localparam int CNT_W = 18; // wide enough for the slow watchdog
  localparam logic [17:0] STAB_CRYSTAL = 18'h0_1000; // 4096 ticks
  localparam logic [17:0] STAB_EXTERNAL = 18'h0_0010; // 16 ticks
  localparam logic [17:0] WDOG_FAST = 18'h0_1FF0; // 8176 ticks
  localparam logic [17:0] WDOG_SLOW = 18'h3_FFF0; // 262128 ticks
  localparam logic [17:0] REC_SHORT = 18'h0_0020; // 32 ticks
  localparam logic [17:0] REC_LONG = 18'h0_1000; // 4096 ticks
  localparam logic [17:0] TB_DIVIDE = 18'h0_0080; // divide by 128

  // ==================================================================
  // option register two, bit 0 last
  typedef struct packed {
    logic reserved; // reads zero
    logic slave_select_pullup_disable;
    logic oscillator_in_stop_enable;
    logic timebase_clock_select;
    logic external_clock_enable;
    logic slow_crystal_select;
    logic crystal_enable;
    logic serial_baud_clock_source;
  } wocfg_opt_two_t;

  // option register one, bit 0 last
  typedef struct packed {
    logic watchdog_rate_select;
    logic voltage_monitor_in_stop;
    logic voltage_monitor_reset_disable;
    logic voltage_monitor_power_disable;
    logic voltage_trip_mode;
    logic short_stop_recovery;
    logic stop_instruction_enable;
    logic watchdog_disable;
  } wocfg_opt_one_t;

  // processor bus request
  typedef struct packed {
    logic [15:0] addr; // byte address
    logic [7:0] wdata; // write data
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
  } wocfg_bus_t;

  // stop mode sequencer
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_RECOVER = 2'b10
  } wocfg_stop_t;

endpackage : wocfg_pkg

// File: src/wocfg_once_reg.sv
`timescale 1ns/1ps
// ====================================================================
// one byte register that takes a single write after each reset
module wocfg_once_reg #(
  parameter logic [7:0] USED_MASK = 8'hFF, // bits that store
  parameter logic [7:0] KEEP_MASK = 8'h00 // bits kept over plain reset
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // stored state
  output logic [7:0] value_q,
  output logic locked_q
);

  logic [7:0] value_d; // next contents
  logic locked_d; // next lock flag

  // next value: first write stores and locks, later writes ignored
  always_comb
  begin
    value_d = value_q;
    locked_d = locked_q;
    if (por)
    begin
      value_d = wocfg_pkg::OPT_RESET;
      locked_d = 1'b0;
    end
    else if (rst)
    begin
      value_d = value_q & KEEP_MASK;
      locked_d = 1'b0;
    end
    else if (wr_en && !locked_q)
    begin
      value_d = wdata & USED_MASK;
      locked_d = 1'b1;
    end
  end

  // register stage
  always_ff @(posedge core_clk)
  begin
    value_q <= value_d;
    locked_q <= locked_d;
  end

endmodule : wocfg_once_reg

// File: src/wocfg_tick_counter.sv
`timescale 1ns/1ps
// ====================================================================
// counts enable ticks and pulses on the last tick of a period
module wocfg_tick_counter #(
  parameter int W = 18 // counter width
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic clear, // restart the period
  input wire logic tick, // one-cycle enable
  input wire logic [W-1:0] limit, // ticks per period
  // result
  output logic done // last tick of the period
);

  logic [W-1:0] count_q; // ticks so far
  logic [W-1:0] count_d; // next count

  // refuse a width that cannot hold a count
  if (W < 2)
  begin : g_bad_width
    $error("tick counter width too small");
  end

  assign done = tick && !clear && (count_q == limit - W'(1));

  // next count: wrap after the period, restart on clear
  always_comb
  begin
    count_d = count_q;
    if (clear || done)
      count_d = '0;
    else if (tick)
      count_d = count_q + W'(1);
  end

  // register stage
  always_ff @(posedge core_clk)
  begin
    if (rst)
      count_q <= '0;
    else
      count_q <= count_d;
  end

endmodule : wocfg_tick_counter

// File: tb/wocfg_top_test.sv
`timescale 1ns/1ps
// ==================================================================
// self-checking bench for the write-once option registers
module wocfg_top_test;
  // clock, resets and stimulus
  logic core_clk;
  logic rst;
  logic por;
  wocfg_pkg::wocfg_bus_t bus;
  logic bus_tick;
  logic osc_tick;
  logic [4:0] ev; // stop, wake, lv wake, service, stab start
  // observed outputs
  logic [7:0] rdata_q;
  logic rvalid_q;
  wocfg_pkg::wocfg_opt_two_t opt_two;
  wocfg_pkg::wocfg_opt_one_t opt_one;
  logic serial_clk_tick, osc_pin_in_is_clock, osc_pin_out_is_crystal;
  logic port_c_bit_four_gpio, port_c_bit_three_gpio;
  logic monitor_expect_crystal, monitor_expect_slow, stab_done;
  logic stab_busy_q, timebase_tick, clocks_running;
  logic slave_select_pullup_en, watchdog_enabled, watchdog_timeout;
  logic low_voltage_monitor_on, low_voltage_reset_en;
  logic voltage_trip_mode, stop_mode, illegal_opcode, cpu_resume;
  logic [3:0] pulses; // resume, timeout, stab done, timebase
  int n_mismatch;
  int n_compared;
  int cyc;

  assign pulses = {cpu_resume, watchdog_timeout, stab_done, timebase_tick};

  // ================================================================
  // device under test
  wocfg_top u_dut (
    .core_clk(core_clk), .rst(rst), .por(por), .bus(bus),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .bus_tick(bus_tick), .osc_tick(osc_tick),
    .stop_exec(ev[0]), .wake_event(ev[1]), .low_voltage_wake(ev[2]),
    .watchdog_service(ev[3]), .stab_start(ev[4]),
    .opt_two(opt_two), .opt_one(opt_one),
    .serial_clk_tick(serial_clk_tick),
    .osc_pin_in_is_clock(osc_pin_in_is_clock),
    .osc_pin_out_is_crystal(osc_pin_out_is_crystal),
    .port_c_bit_four_gpio(port_c_bit_four_gpio),
    .port_c_bit_three_gpio(port_c_bit_three_gpio),
    .monitor_expect_crystal(monitor_expect_crystal),
    .monitor_expect_slow(monitor_expect_slow),
    .stab_done(stab_done), .stab_busy_q(stab_busy_q),
    .timebase_tick(timebase_tick), .clocks_running(clocks_running),
    .slave_select_pullup_en(slave_select_pullup_en),
    .watchdog_enabled(watchdog_enabled),
    .watchdog_timeout(watchdog_timeout),
    .low_voltage_monitor_on(low_voltage_monitor_on),
    .low_voltage_reset_en(low_voltage_reset_en),
    .voltage_trip_mode(voltage_trip_mode), .stop_mode(stop_mode),
    .illegal_opcode(illegal_opcode), .cpu_resume(cpu_resume)
  );

  // ================================================================
  // clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // cuts a hung run short well above the expected length
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 50000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  // ================================================================
  // compare tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  task automatic chk_count(input int got, input int exp);
    n_compared = n_compared + 1;
    if (got != exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_count

  // ================================================================
  // drivers
  task automatic do_reset(input logic full);
    @(posedge core_clk);
    rst <= 1'b1;
    por <= full;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    por <= 1'b0;
  endtask : do_reset

  // one-cycle write strobe
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    // let the stored contents settle before anyone looks
    @(negedge core_clk);
  endtask : bus_wr

  // read and judge the answer one cycle later
  task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    chk_bit(rvalid_q, 1'b1);
    chk_byte(rdata_q, exp);
  endtask : bus_rd

  // one-cycle event pulse; returns on the edge that takes it
  task automatic pulse_in(input int idx);
    @(posedge core_clk);
    ev[idx] <= 1'b1;
    @(posedge core_clk);
    ev[idx] <= 1'b0;
  endtask : pulse_in

  // cycles from now until the chosen output pulses
  task automatic count_pulse(input int idx, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n = n + 1;
    end
    while (pulses[idx] !== 1'b1 && n < lim + 8);
  endtask : count_pulse

  // ================================================================
  // scenarios
  task automatic t_reset_values;
    bus_rd(16'h001E, 8'h00);
    bus_rd(16'h001F, 8'h00);
    chk_bit(slave_select_pullup_en, 1'b1);
    chk_bit(watchdog_enabled, 1'b1);
    chk_bit(low_voltage_monitor_on, 1'b1);
    chk_bit(port_c_bit_four_gpio, 1'b1);
    chk_bit(low_voltage_reset_en, 1'b1);
    chk_bit(voltage_trip_mode, 1'b0);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_reg_two_once;
    int n;
    bus_wr(16'h001E, 8'hFF);
    bus_rd(16'h001E, 8'h7F);
    bus_wr(16'h001E, 8'h00);
    bus_rd(16'h001E, 8'h7F);
    chk_bit(osc_pin_in_is_clock, 1'b1);
    chk_bit(osc_pin_out_is_crystal, 1'b1);
    chk_bit(port_c_bit_three_gpio, 1'b0);
    chk_bit(monitor_expect_crystal, 1'b1);
    chk_bit(monitor_expect_slow, 1'b1);
    chk_bit(slave_select_pullup_en, 1'b0);
    @(posedge core_clk);
    bus_tick <= 1'b1;
    osc_tick <= 1'b0;
    @(negedge core_clk);
    chk_bit(serial_clk_tick, 1'b1);
    @(posedge core_clk);
    bus_tick <= 1'b0;
    osc_tick <= 1'b1;
    count_pulse(0, 128, n);
    count_pulse(0, 128, n);
    chk_count(n, 128);
    $display("test reg_two_once done");
  endtask : t_reg_two_once

  task automatic t_stop_cycle;
    int n;
    bus_wr(16'h001F, 8'h0E);
    bus_rd(16'h001F, 8'h0E);
    bus_rd(16'h0020, 8'h00);
    pulse_in(0);
    @(negedge core_clk);
    chk_bit(stop_mode, 1'b1);
    chk_bit(clocks_running, 1'b1);
    chk_bit(low_voltage_monitor_on, 1'b0);
    pulse_in(1);
    count_pulse(3, 32, n);
    chk_count(n, 32);
    pulse_in(0);
    pulse_in(2);
    count_pulse(3, 4096, n);
    chk_count(n, 4096);
    $display("test stop_cycle done");
  endtask : t_stop_cycle

  task automatic t_plain_reset;
    int n;
    do_reset(1'b0);
    bus_rd(16'h001F, 8'h08);
    chk_bit(voltage_trip_mode, 1'b1);
    bus_rd(16'h001E, 8'h00);
    bus_wr(16'h001E, 8'h02);
    chk_bit(osc_pin_in_is_clock, 1'b0);
    chk_bit(port_c_bit_three_gpio, 1'b1);
    pulse_in(4);
    count_pulse(1, 4096, n);
    chk_count(n, 4096);
    bus_wr(16'h001F, 8'h88);
    bus_rd(16'h001F, 8'h88);
    pulse_in(3);
    count_pulse(2, 8176, n);
    chk_count(n, 8176);
    @(posedge core_clk);
    ev[0] <= 1'b1;
    @(negedge core_clk);
    chk_bit(illegal_opcode, 1'b1);
    @(posedge core_clk);
    ev[0] <= 1'b0;
    @(negedge core_clk);
    chk_bit(stop_mode, 1'b0);
    $display("test plain_reset done");
  endtask : t_plain_reset

  task automatic t_power_reset;
    int n;
    do_reset(1'b1);
    bus_rd(16'h001F, 8'h00);
    bus_wr(16'h001E, 8'h08);
    chk_bit(osc_pin_out_is_crystal, 1'b0);
    chk_bit(port_c_bit_four_gpio, 1'b0);
    chk_bit(monitor_expect_crystal, 1'b0);
    pulse_in(4);
    count_pulse(1, 16, n);
    chk_count(n, 16);
    bus_wr(16'h001F, 8'h13);
    chk_bit(watchdog_enabled, 1'b0);
    chk_bit(low_voltage_monitor_on, 1'b0);
    pulse_in(0);
    @(negedge core_clk);
    chk_bit(clocks_running, 1'b0);
    pulse_in(1);
    count_pulse(3, 4096, n);
    chk_count(n, 4096);
    $display("test power_reset done");
  endtask : t_power_reset

  // ================================================================
  // closing report
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // ================================================================
  // main sequence
  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    cyc = 0;
    rst = 1'b1;
    por = 1'b1;
    bus = '0;
    bus_tick = 1'b0;
    osc_tick = 1'b1;
    ev = 5'h00;
    do_reset(1'b1);
    t_reset_values();
    t_reg_two_once();
    t_stop_cycle();
    t_plain_reset();
    t_power_reset();
    end_of_test();
  end
endmodule : wocfg_top_test
